// [rtl/circ_addr_regs.svh]
// Purpose: offsets, reset values and field positions
// Assumes: 32-bit AHB-Lite word per register
// Notes:   boundary registers hold byte addresses
//
// Function
// [RULE_01] the X pointer select is bits 3:0 of the control register.
// [RULE_02] X wraps only if x_pointer_select is not 15 and bit 15 is set.
// [RULE_03] the Y pointer select is bits 7:4 of the control register.
// [RULE_04] Y wraps only if y_pointer_select is not 15 and bit 14 is set.
// [RULE_05] select 15 disables wrapping on both X generators, or on Y.
// [RULE_06] four 16-bit boundary registers hold X and Y start and end.
// [RULE_07] Y circular addresses are word-sized, so bit 0 is zero.
// [RULE_08] length comes from end minus start, up to 32K words.
// [RULE_09] one circular buffer is active in X and one in Y at a time.
// [RULE_10] X wrapping also applies to program space pointers.
// [RULE_11] software uses non power-of-two buffers in one direction.
// [RULE_12] power-of-two buffers check both boundaries.
// [RULE_13] software should not pick the frame or stack pointer.
// [RULE_14] stepping past end gives start; below start gives end.
`ifndef CIRC_ADDR_REGS_SVH
`define CIRC_ADDR_REGS_SVH

`define CA_OFF_CTRL    8'h00
`define CA_OFF_XSTART  8'h04
`define CA_OFF_XEND    8'h08
`define CA_OFF_YSTART  8'h0C
`define CA_OFF_YEND    8'h10
`define CA_OFF_XLAST   8'h14
`define CA_OFF_YLAST   8'h18

`define CA_CTRL_RESET  16'h00FF
`define CA_BOUND_RESET 16'h0000
`define CA_SEL_OFF     4'hF
`define CA_XSEL_LSB    0
`define CA_YSEL_LSB    4
`define CA_XEN_BIT     15
`define CA_YEN_BIT     14

`endif

// [rtl/circ_addr_pkg.sv]
// Purpose: types shared by the circular address generator
// Assumes: 16-bit data addresses
// Notes:   step is a signed byte offset
`default_nettype none
package circ_addr_pkg;
   // pointer update from the execution pipeline
   typedef struct packed {
      logic        valid;
      logic        prog_space;
      logic [3:0]  w_index;
      logic [15:0] addr;
      logic [15:0] step;
   } agu_req_t;

   // generated effective address
   typedef struct packed {
      logic        valid;
      logic        wrapped;
      logic        circular;
      logic [15:0] ea;
   } agu_rsp_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] xs;
      logic [15:0] xe;
      logic [15:0] ys;
      logic [15:0] ye;
      logic [15:0] x_last;
      logic [15:0] y_last;
   } regs_t;

   typedef struct packed {
      regs_t    regs;
      agu_rsp_t xrd;
      agu_rsp_t xwr;
      agu_rsp_t y;
   } core_state_t;

   typedef struct packed {
      logic        rd_pend;
      logic        wr_pend;
      logic [7:0]  addr;
      logic [31:0] rdata;
   } ahb_state_t;
endpackage
`default_nettype wire

// [rtl/ahb_reg_slave.sv]
// Purpose: AHB-Lite slave front end for a small register file
// Assumes: single word transfers, one slave on the bus
// Notes:   writes take no wait state, reads take one
`default_nettype none
`timescale 1ns/1ps
module ahb_reg_slave (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             wr_en,
   output logic [7:0]       reg_addr,
   output logic [31:0]      wr_data,
   input  wire logic [31:0] rd_data
);
   circ_addr_pkg::ahb_state_t s;
   circ_addr_pkg::ahb_state_t next_s;
   logic                      accept;

   // hsize is not decoded: only whole words are supported
   assign accept    = hsel && htrans[1] && hready;
   assign hreadyout = !s.rd_pend;
   assign hresp     = 1'b0;
   assign hrdata    = s.rdata;
   assign wr_en     = s.wr_pend;
   assign reg_addr  = s.addr;
   assign wr_data   = hwdata;

   // read data is sampled one cycle late so a write just before lands
   always_comb begin
      next_s         = s;
      next_s.wr_pend = 1'b0;
      next_s.rd_pend = 1'b0;
      if (s.rd_pend) begin
         next_s.rdata = rd_data;
      end
      if (accept) begin
         next_s.addr    = haddr[7:0];
         next_s.wr_pend = hwrite;
         next_s.rd_pend = !hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// [rtl/modulo_step.sv]
// Purpose: one pointer step with circular wrap at the boundaries
// Assumes: boundaries hold byte addresses, end is the last byte
// Notes:   purely combinational, the caller registers the result
`default_nettype none
`timescale 1ns/1ps
module modulo_step #(
   parameter bit WORD_ONLY = 1'b0
) (
   input  wire logic [15:0] addr,
   input  wire logic [15:0] step,
   input  wire logic [15:0] start_addr,
   input  wire logic [15:0] end_addr,
   input  wire logic        active,
   output logic [15:0]      ea,
   output logic             wrapped
);
   logic [15:0] sum;
   logic [15:0] len;
   logic        pow2;
   logic        over;
   logic        under;
   logic        dec;

   // length is implicit: no length register exists
   assign sum   = addr + step;
   assign len   = end_addr - start_addr + 16'h0001; // [RULE_08]
   assign pow2  = ((len & (len - 16'h0001)) == 16'h0000);
   assign over  = sum > end_addr;
   assign under = sum < start_addr;
   assign dec   = step[15];

   // non power-of-two buffers only check the side they move towards
   always_comb begin
      ea      = sum;
      wrapped = 1'b0;
      if (active) begin
         if ((pow2 || !dec) && over) begin // [RULE_12]
            ea      = start_addr; // [RULE_14]
            wrapped = 1'b1;
         end else if ((pow2 || dec) && under) begin // [RULE_12]
            ea      = end_addr; // [RULE_14]
            wrapped = 1'b1;
         end
         if (WORD_ONLY) begin
            ea[0] = 1'b0; // [RULE_07]
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/circular_buffer_address_gen.sv]
// Purpose: circular buffer address generation for X and Y spaces
// Assumes: pipeline presents pointer updates on the core clock
// Notes:   one buffer per space; X read and X write share one buffer
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`include "circ_addr_regs.svh"
`default_nettype none
`timescale 1ns/1ps
module circular_buffer_address_gen (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   input  wire circ_addr_pkg::agu_req_t xrd_req,
   input  wire circ_addr_pkg::agu_req_t xwr_req,
   input  wire circ_addr_pkg::agu_req_t y_req,
   output circ_addr_pkg::agu_rsp_t      xrd_rsp,
   output circ_addr_pkg::agu_rsp_t      xwr_rsp,
   output circ_addr_pkg::agu_rsp_t      y_rsp
);
   circ_addr_pkg::core_state_t s;
   circ_addr_pkg::core_state_t next_s;

   logic        wr_en;
   logic [7:0]  reg_addr;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic [3:0]  x_sel;
   logic [3:0]  y_sel;
   logic        x_on;
   logic        y_on;
   logic        xrd_act;
   logic        xwr_act;
   logic        y_act;
   logic [15:0] xrd_ea;
   logic [15:0] xwr_ea;
   logic [15:0] y_ea;
   logic        xrd_wrap;
   logic        xwr_wrap;
   logic        y_wrap;

   // a space is on only with its enable set and a select other than 15
   function automatic logic space_on(input logic [3:0] sel,
                                     input logic       en);
      space_on = en && (sel != `CA_SEL_OFF);
   endfunction

   // word read mux; unmapped offsets read zero
   function automatic logic [31:0] reg_read(
      input logic [7:0]           a,
      input circ_addr_pkg::regs_t r);
      reg_read = 32'h0000_0000;
      case (a)
         `CA_OFF_CTRL:   reg_read[15:0] = r.ctrl;
         `CA_OFF_XSTART: reg_read[15:0] = r.xs;
         `CA_OFF_XEND:   reg_read[15:0] = r.xe;
         `CA_OFF_YSTART: reg_read[15:0] = r.ys;
         `CA_OFF_YEND:   reg_read[15:0] = r.ye;
         `CA_OFF_XLAST:  reg_read[15:0] = r.x_last;
         `CA_OFF_YLAST:  reg_read[15:0] = r.y_last;
         default:        reg_read = 32'h0000_0000;
      endcase
   endfunction

   ahb_reg_slave u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .wr_en     (wr_en),
      .reg_addr  (reg_addr),
      .wr_data   (wr_data),
      .rd_data   (rd_data)
   );

   assign rd_data = reg_read(reg_addr, s.regs);

   // pointer selects and enables from the control register
   assign x_sel = s.regs.ctrl[`CA_XSEL_LSB +: 4]; // [RULE_01]
   assign y_sel = s.regs.ctrl[`CA_YSEL_LSB +: 4]; // [RULE_03]
   assign x_on  = space_on(x_sel, s.regs.ctrl[`CA_XEN_BIT]); // [RULE_02]
   assign y_on  = space_on(y_sel, s.regs.ctrl[`CA_YEN_BIT]); // [RULE_04]

   // only the selected W register wraps; program space is not excluded
   assign xrd_act = x_on && (xrd_req.w_index == x_sel); // [RULE_05] [RULE_10]
   assign xwr_act = x_on && (xwr_req.w_index == x_sel); // [RULE_05] [RULE_10]
   assign y_act   = y_on && (y_req.w_index == y_sel); // [RULE_05]

   // X read and write share one buffer, so one X buffer at a time
   modulo_step #(.WORD_ONLY(1'b0)) u_xrd ( // [RULE_09]
      .addr       (xrd_req.addr),
      .step       (xrd_req.step),
      .start_addr (s.regs.xs),
      .end_addr   (s.regs.xe),
      .active     (xrd_act),
      .ea         (xrd_ea),
      .wrapped    (xrd_wrap)
   );

   modulo_step #(.WORD_ONLY(1'b0)) u_xwr (
      .addr       (xwr_req.addr),
      .step       (xwr_req.step),
      .start_addr (s.regs.xs),
      .end_addr   (s.regs.xe),
      .active     (xwr_act),
      .ea         (xwr_ea),
      .wrapped    (xwr_wrap)
   );

   // Y circular addresses are always words
   modulo_step #(.WORD_ONLY(1'b1)) u_y ( // [RULE_07]
      .addr       (y_req.addr),
      .step       (y_req.step),
      .start_addr (s.regs.ys),
      .end_addr   (s.regs.ye),
      .active     (y_act),
      .ea         (y_ea),
      .wrapped    (y_wrap)
   );

   assign xrd_rsp = s.xrd;
   assign xwr_rsp = s.xwr;
   assign y_rsp   = s.y;

   // register writes and registered address results
   always_comb begin
      next_s = s;
      if (wr_en) begin
         case (reg_addr)
            `CA_OFF_CTRL:   next_s.regs.ctrl = wr_data[15:0];
            `CA_OFF_XSTART: next_s.regs.xs   = wr_data[15:0]; // [RULE_06]
            `CA_OFF_XEND:   next_s.regs.xe   = wr_data[15:0]; // [RULE_06]
            `CA_OFF_YSTART: next_s.regs.ys   = wr_data[15:0]; // [RULE_06]
            `CA_OFF_YEND:   next_s.regs.ye   = wr_data[15:0]; // [RULE_06]
            default:        next_s.regs      = s.regs;
         endcase
      end
      next_s.xrd = '{valid: xrd_req.valid, wrapped: xrd_wrap,
                     circular: xrd_act, ea: xrd_ea};
      next_s.xwr = '{valid: xwr_req.valid, wrapped: xwr_wrap,
                     circular: xwr_act, ea: xwr_ea};
      next_s.y   = '{valid: y_req.valid, wrapped: y_wrap,
                     circular: y_act, ea: y_ea};
      // the write generator wins when both X sides step together
      if (xwr_req.valid) begin
         next_s.regs.x_last = xwr_ea;
      end else if (xrd_req.valid) begin
         next_s.regs.x_last = xrd_ea;
      end
      if (y_req.valid) begin
         next_s.regs.y_last = y_ea;
      end
   end

   // bounds reset to zero, both spaces start disabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s           <= '0;
         s.regs.ctrl <= `CA_CTRL_RESET;
         s.regs.xs   <= `CA_BOUND_RESET;
         s.regs.xe   <= `CA_BOUND_RESET;
         s.regs.ys   <= `CA_BOUND_RESET;
         s.regs.ye   <= `CA_BOUND_RESET;
      end else begin
         s <= next_s;
      end
   end

   // checking helpers
   logic [15:0] chk_xrd_sum;
   logic [15:0] chk_xrd_len;
   logic        chk_xrd_pow2;
   assign chk_xrd_sum  = xrd_req.addr + xrd_req.step;
   assign chk_xrd_len  = s.regs.xe - s.regs.xs + 16'h0001;
   assign chk_xrd_pow2 = (chk_xrd_len & (chk_xrd_len - 16'h0001)) == 16'h0000;

   // Y copies: the power-of-two case is only exercised on the Y buffer
   logic [15:0] chk_y_sum;
   logic [15:0] chk_y_len;
   logic        chk_y_pow2;
   assign chk_y_sum  = y_req.addr + y_req.step;
   assign chk_y_len  = s.regs.ye - s.regs.ys + 16'h0001;
   assign chk_y_pow2 = (chk_y_len & (chk_y_len - 16'h0001)) == 16'h0000;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_xsel_field: assert property ( // [RULE_01]
      xrd_req.valid && s.regs.ctrl[15] && s.regs.ctrl[3:0] != 4'hF
      && xrd_req.w_index == s.regs.ctrl[3:0] |=> xrd_rsp.circular)
      else $error("x select field not honoured");

   a_x_enable_gate: assert property ( // [RULE_02]
      xrd_req.valid && !s.regs.ctrl[15] |=> !xrd_rsp.circular)
      else $error("x wrapped while disabled");

   a_ysel_field: assert property ( // [RULE_03]
      y_req.valid && s.regs.ctrl[14] && s.regs.ctrl[7:4] != 4'hF
      && y_req.w_index == s.regs.ctrl[7:4] |=> y_rsp.circular)
      else $error("y select field not honoured");

   a_y_enable_gate: assert property ( // [RULE_04]
      y_req.valid && !s.regs.ctrl[14] |=> !y_rsp.circular)
      else $error("y wrapped while disabled");

   a_x_sel_off: assert property ( // [RULE_05]
      s.regs.ctrl[3:0] == 4'hF && (xrd_req.valid || xwr_req.valid)
      |=> !xrd_rsp.circular && !xwr_rsp.circular)
      else $error("x select 15 did not disable");

   a_y_sel_off: assert property ( // [RULE_05]
      y_req.valid && s.regs.ctrl[7:4] == 4'hF |=> !y_rsp.circular)
      else $error("y select 15 did not disable");

   a_bound_load: assert property ( // [RULE_06]
      wr_en && reg_addr == 8'h04 |=> s.regs.xs == $past(wr_data[15:0]))
      else $error("x start boundary not loaded");

   a_y_word_ea: assert property ( // [RULE_07]
      y_rsp.valid && y_rsp.circular |-> !y_rsp.ea[0])
      else $error("y circular address is odd");

   a_prog_space: assert property ( // [RULE_10]
      xrd_req.valid && xrd_req.prog_space && xrd_act
      |=> xrd_rsp.valid && xrd_rsp.circular)
      else $error("program space pointer not wrapped");

   a_inc_wrap: assert property ( // [RULE_14]
      xrd_req.valid && xrd_act && !xrd_req.step[15]
      && chk_xrd_sum > s.regs.xe
      |=> xrd_rsp.wrapped && xrd_rsp.ea == $past(s.regs.xs))
      else $error("incrementing wrap did not give start");

   a_pow2_down: assert property ( // [RULE_12]
      xrd_req.valid && xrd_act && chk_xrd_pow2 && !xrd_req.step[15]
      && chk_xrd_sum < s.regs.xs |=> xrd_rsp.ea == $past(s.regs.xe))
      else $error("power of two buffer missed lower check");

   // a decrementing pointer past the end of a power-of-two buffer
   // still wraps, which a one-direction buffer would not catch
   a_pow2_up: assert property ( // [RULE_12]
      y_req.valid && y_act && chk_y_pow2 && y_req.step[15]
      && chk_y_sum > s.regs.ye
      |=> y_rsp.wrapped && y_rsp.ea == {$past(s.regs.ys[15:1]), 1'b0})
      else $error("power of two buffer missed upper check");

   a_x_last: assert property (
      xwr_req.valid |=> s.regs.x_last == $past(xwr_ea))
      else $error("last x address not recorded");

   a_read_wait: assert property (
      hsel && htrans[1] && hready && !hwrite
      |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   c_x_wrap: cover property (xrd_rsp.valid && xrd_rsp.wrapped);
   c_y_wrap: cover property (y_rsp.valid && y_rsp.wrapped);
   c_xwr_wrap: cover property (xwr_rsp.valid && xwr_rsp.wrapped);
   c_bus_read: cover property (!hreadyout ##1 hreadyout);
   c_pow2_up: cover property (y_req.valid && y_act && y_req.step[15]
                              && chk_y_sum > s.regs.ye);
endmodule
`default_nettype wire

// [verif/pipe_model.sv]
// Purpose: execution pipeline model that issues pointer updates
// Assumes: one update per port per cycle, valid is a one-cycle pulse
// Notes:   idle ports show inverted fields so stale values never match
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
   input  wire logic               hclk,
   output circ_addr_pkg::agu_req_t xrd_req,
   output circ_addr_pkg::agu_req_t xwr_req,
   output circ_addr_pkg::agu_req_t y_req
);
   // all ports quiet until the bench asks for an update
   initial begin
      xrd_req = '0;
      xwr_req = '0;
      y_req   = '0;
   end

   // callers pick pointers other than the frame and stack ones
   // and step non power-of-two buffers in one direction only
   task automatic send(input circ_addr_pkg::agu_req_t a,
                       input circ_addr_pkg::agu_req_t b,
                       input circ_addr_pkg::agu_req_t c);
      @(posedge hclk);
      xrd_req <= a;
      xwr_req <= b;
      y_req   <= c;
      @(posedge hclk);
      xrd_req <= {1'b0, ~a[36:0]};
      xwr_req <= {1'b0, ~b[36:0]};
      y_req   <= {1'b0, ~c[36:0]};
   endtask
endmodule
`default_nettype wire

// [verif/tb_circular_buffer_address_gen.sv]
// Purpose: self-checking bench for the circular address generator
// Assumes: single AHB-Lite master, hready fed back from hreadyout
// Notes:   expected addresses worked out by hand from the wrap rules
`timescale 1ns/1ps
`default_nettype none
module tb_circular_buffer_address_gen;
   logic                    hclk;
   logic                    hresetn;
   logic                    hsel;
   logic [31:0]             haddr;
   logic [1:0]              htrans;
   logic                    hwrite;
   logic [2:0]              hsize;
   logic [31:0]             hwdata;
   wire logic               hreadyout;
   wire logic               hresp;
   wire logic [31:0]        hrdata;
   circ_addr_pkg::agu_req_t xrd_req;
   circ_addr_pkg::agu_req_t xwr_req;
   circ_addr_pkg::agu_req_t y_req;
   circ_addr_pkg::agu_rsp_t xrd_rsp;
   circ_addr_pkg::agu_rsp_t xwr_rsp;
   circ_addr_pkg::agu_rsp_t y_rsp;
   circ_addr_pkg::agu_req_t none;
   int                      mismatches;
   int                      checks;

   circular_buffer_address_gen uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .xrd_req(xrd_req), .xwr_req(xwr_req),
      .y_req(y_req), .xrd_rsp(xrd_rsp), .xwr_rsp(xwr_rsp), .y_rsp(y_rsp));

   pipe_model pm (
      .hclk(hclk), .xrd_req(xrd_req), .xwr_req(xwr_req), .y_req(y_req));

   // 250 MHz core clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask

   // one single AHB transfer; waits for hready in both phases
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q, exp);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask

   function automatic circ_addr_pkg::agu_req_t mk(input logic [3:0] w,
      input logic [15:0] a, input logic [15:0] s, input logic pg);
      return {1'b1, pg, w, a, s};
   endfunction

   // compare a response taken just after the edge that registered it
   task automatic rchk(input circ_addr_pkg::agu_rsp_t r, input logic wp,
                       input logic ci, input logic [15:0] ea);
      chk({13'h0000, r}, {13'h0000, 1'b1, wp, ci, ea});
   endtask

   task automatic t_regs;
      rdc(8'h00, 32'h0000_00FF);
      rdc(8'h04, 32'h0000_0000);
      wr(8'h04, 32'hABCD_1000);
      wr(8'h08, 32'h0000_1009);
      wr(8'h0C, 32'h0000_2000);
      wr(8'h10, 32'h0000_201F);
      rdc(8'h04, 32'h0000_1000);
      rdc(8'h08, 32'h0000_1009);
      rdc(8'h0C, 32'h0000_2000);
      rdc(8'h10, 32'h0000_201F);
      wr(8'h14, 32'h0000_5555);
      rdc(8'h14, 32'h0000_0000);
      wr(8'h40, 32'h0000_1234);
      rdc(8'h40, 32'h0000_0000);
   endtask

   // ten-byte X buffer stepped upwards only
   task automatic t_xinc;
      wr(8'h00, 32'h0000_80F3);
      rdc(8'h00, 32'h0000_80F3);
      pm.send(mk(4'h3, 16'h1008, 16'h0002, 1'b0),
              mk(4'h3, 16'h1006, 16'h0002, 1'b1), none);
      #1;
      rchk(xrd_rsp, 1'b1, 1'b1, 16'h1000);
      rchk(xwr_rsp, 1'b0, 1'b1, 16'h1008);
      pm.send(mk(4'h4, 16'h1008, 16'h0002, 1'b0),
              mk(4'h3, 16'h1008, 16'h0004, 1'b1), none);
      #1;
      rchk(xrd_rsp, 1'b0, 1'b0, 16'h100A);
      rchk(xwr_rsp, 1'b1, 1'b1, 16'h1000);
      rdc(8'h14, 32'h0000_1000);
   endtask

   // 32-byte Y buffer is a power of two, so both directions wrap
   task automatic t_ydec;
      wr(8'h00, 32'h0000_4053);
      pm.send(mk(4'h3, 16'h1008, 16'h0002, 1'b0), none,
              mk(4'h5, 16'h2000, 16'hFFFE, 1'b0));
      #1;
      rchk(xrd_rsp, 1'b0, 1'b0, 16'h100A);
      rchk(y_rsp, 1'b1, 1'b1, 16'h201E);
      pm.send(none, none, mk(4'h5, 16'h201E, 16'h0002, 1'b0));
      #1;
      rchk(y_rsp, 1'b1, 1'b1, 16'h2000);
      pm.send(none, none, mk(4'h5, 16'h2003, 16'h0002, 1'b0));
      #1;
      rchk(y_rsp, 1'b0, 1'b1, 16'h2004);
      pm.send(none, none, mk(4'h5, 16'h2022, 16'hFFFE, 1'b0));
      #1;
      rchk(y_rsp, 1'b1, 1'b1, 16'h2000);
      pm.send(none, none, mk(4'h3, 16'h201E, 16'h0002, 1'b0));
      #1;
      rchk(y_rsp, 1'b0, 1'b0, 16'h2020);
   endtask

   // enables set but both selects parked at 15
   task automatic t_sel15;
      wr(8'h00, 32'h0000_C0FF);
      pm.send(mk(4'h7, 16'h1008, 16'h0002, 1'b0),
              mk(4'h7, 16'h1008, 16'h0002, 1'b0),
              mk(4'h7, 16'h201E, 16'h0002, 1'b0));
      #1;
      rchk(xrd_rsp, 1'b0, 1'b0, 16'h100A);
      rchk(xwr_rsp, 1'b0, 1'b0, 16'h100A);
      rchk(y_rsp, 1'b0, 1'b0, 16'h2020);
   endtask

   // one buffer live in each space in the same cycle
   task automatic t_both;
      wr(8'h00, 32'h0000_C053);
      pm.send(mk(4'h3, 16'h1008, 16'h0002, 1'b0), none,
              mk(4'h5, 16'h201E, 16'h0002, 1'b0));
      #1;
      rchk(xrd_rsp, 1'b1, 1'b1, 16'h1000);
      rchk(y_rsp, 1'b1, 1'b1, 16'h2000);
      rdc(8'h18, 32'h0000_2000);
   endtask

   task automatic wrap_up;
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // a hung bus wait would otherwise stall the run forever
   initial begin
      #100us;
      mismatches++;
      wrap_up();
   end

   initial begin
      mismatches = 0;
      checks = 0;
      none = '0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_xinc();
      t_ydec();
      t_sel15();
      t_both();
      repeat (4) @(posedge hclk);
      wrap_up();
   end
endmodule
`default_nettype wire
